//--- logic/ask_pkg.sv
// Constants for the accessory switch router and key classifier.
// Assumes one 250 MHz clock and a byte-wide register port from the host link.
package ask_pkg;

  // ----------------------------------------------------------------
  // Accessory state, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [7:0] {
    ASK_NONE    = 8'h01,
    ASK_DETECT  = 8'h02,
    ASK_P3      = 8'h04,
    ASK_P3_FM   = 8'h08,
    ASK_RING2   = 8'h10,
    ASK_RING2_FM = 8'h20,
    ASK_STD     = 8'h40,
    ASK_STD_FM  = 8'h80
  } ask_acc_e;

  // ----------------------------------------------------------------
  // Switch vector bit positions, 1 means On
  // ----------------------------------------------------------------
  localparam int SW_W     = 10;
  localparam int SW_FIRST = 0;
  localparam int SW_CODEC = 1;
  localparam int SW_M2S   = 2;
  localparam int SW_M2R   = 3;
  localparam int SW_G2S   = 4;
  localparam int SW_G2R   = 5;

  // Switch sets per accessory state
  localparam logic [SW_W-1:0] SWS_NONE     = 10'h300;
  localparam logic [SW_W-1:0] SWS_DETECT   = 10'h002;
  localparam logic [SW_W-1:0] SWS_P3       = 10'h3F1;
  localparam logic [SW_W-1:0] SWS_P3_FM    = 10'h061;
  localparam logic [SW_W-1:0] SWS_RING2    = 10'h298;
  localparam logic [SW_W-1:0] SWS_RING2_FM = 10'h098;
  localparam logic [SW_W-1:0] SWS_STD      = 10'h164;
  localparam logic [SW_W-1:0] SWS_STD_FM   = 10'h064;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_BOUND_LOW  = 8'h0D;
  localparam logic [7:0] ADDR_BOUND_MID  = 8'h0E;
  localparam logic [7:0] ADDR_BOUND_HIGH = 8'h0F;
  localparam int         TH_W            = 7;
  localparam logic [TH_W-1:0] RST_BOUND_LOW  = 7'h10;
  localparam logic [TH_W-1:0] RST_BOUND_MID  = 7'h22;
  localparam logic [TH_W-1:0] RST_BOUND_HIGH = 7'h35;
  localparam logic [7:0] RD_UNMAPPED     = 8'h00;
  localparam int         OHM_PER_LSB     = 6;

  // Key index codes
  localparam int         KEYS   = 4;
  localparam logic [1:0] KEY_1  = 2'h0;
  localparam logic [1:0] KEY_2  = 2'h1;
  localparam logic [1:0] KEY_3  = 2'h2;
  localparam logic [1:0] KEY_4  = 2'h3;

endpackage

//--- logic/ask_core.sv
// Accessory switch router and key press classifier.
// Assumes detection, debounce and the host link run on clk and feed this block.
`timescale 1ns/10ps
module ask_core
  import ask_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire ask_acc_e        acc_state,
  input  wire logic            manual_en,
  input  wire logic [SW_W-1:0] manual_sw,
  input  wire logic [7:0]      reg_addr,
  input  wire logic [7:0]      reg_wdata,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  input  wire logic [TH_W-1:0] sleeve_code,
  input  wire logic [TH_W-1:0] ring2_code,
  input  wire logic [TH_W-1:0] sleeve_kelvin_code,
  input  wire logic [TH_W-1:0] ring2_kelvin_input,
  input  wire logic            key_press_valid,
  input  wire logic            key_release_valid,
  input  wire logic [KEYS-1:0] press_clear,
  input  wire logic [KEYS-1:0] release_clear,
  output logic [SW_W-1:0]      switch_on,
  output logic [7:0]           reg_rdata,
  output logic [1:0]           key_bin,
  output logic                 mic_on_ring2,
  output logic [KEYS-1:0]      key_press_flag,
  output logic [KEYS-1:0]      key_release_flag,
  output logic                 key_irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [SW_W-1:0] sw_reg;
  logic [SW_W-1:0] sw_next;
  logic [TH_W-1:0] th_low_reg;
  logic [TH_W-1:0] th_mid_reg;
  logic [TH_W-1:0] th_high_reg;
  logic [7:0]      rdata_reg;
  logic [7:0]      rdata_next;
  logic [1:0]      bin_reg;
  logic [1:0]      bin_next;
  logic            loc_reg;
  logic            loc_next;
  logic [KEYS-1:0] press_reg;
  logic [KEYS-1:0] release_reg;
  logic [KEYS-1:0] press_hot;
  logic [KEYS-1:0] rel_hot;
  logic            irq_reg;
  logic [TH_W-1:0] mic_code;
  logic [TH_W-1:0] gnd_code;
  logic [TH_W-1:0] eq_code;
  logic [1:0]      last_bin_reg;

  assign switch_on        = sw_reg;
  assign reg_rdata        = rdata_reg;
  assign key_bin          = bin_reg;
  assign mic_on_ring2     = loc_reg;
  assign key_press_flag   = press_reg;
  assign key_release_flag = release_reg;
  assign key_irq          = irq_reg;

  // ----------------------------------------------------------------
  // Switch routing
  // ----------------------------------------------------------------
  // Automatic table lookup; an unknown code falls back to the safe default
  always_comb begin
    case (acc_state)
      ASK_NONE:     sw_next = SWS_NONE;
      ASK_DETECT:   sw_next = SWS_DETECT;
      ASK_P3:       sw_next = SWS_P3;
      ASK_P3_FM:    sw_next = SWS_P3_FM;
      ASK_RING2:    sw_next = SWS_RING2;
      ASK_RING2_FM: sw_next = SWS_RING2_FM;
      ASK_STD:      sw_next = SWS_STD;
      ASK_STD_FM:   sw_next = SWS_STD_FM;
      default:      sw_next = SWS_NONE;
    endcase
    if (manual_en) begin
      sw_next = manual_sw;
    end
  end

  // Reset leaves depletion transistors on so the ground never floats
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_reg <= SWS_NONE;
    end else begin
      sw_reg <= sw_next;
    end
  end

  // ----------------------------------------------------------------
  // Threshold registers
  // ----------------------------------------------------------------
  // Writes land at once; the classifier reads these directly
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      th_low_reg  <= RST_BOUND_LOW;
      th_mid_reg  <= RST_BOUND_MID;
      th_high_reg <= RST_BOUND_HIGH;
    end else if (reg_wr) begin
      // Top data bit dropped on write
      if (reg_addr == ADDR_BOUND_LOW) begin
        th_low_reg <= reg_wdata[TH_W-1:0];
      end
      if (reg_addr == ADDR_BOUND_MID) begin
        th_mid_reg <= reg_wdata[TH_W-1:0];
      end
      if (reg_addr == ADDR_BOUND_HIGH) begin
        th_high_reg <= reg_wdata[TH_W-1:0];
      end
    end
  end

  // Read mux, registered so the data port comes from a flop
  always_comb begin
    case (reg_addr)
      ADDR_BOUND_LOW:  rdata_next = {1'b0, th_low_reg};
      ADDR_BOUND_MID:  rdata_next = {1'b0, th_mid_reg};
      ADDR_BOUND_HIGH: rdata_next = {1'b0, th_high_reg};
      default:         rdata_next = RD_UNMAPPED;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= RD_UNMAPPED;
    end else if (reg_rd) begin
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Measurement
  // ----------------------------------------------------------------
  // Mic sits on ring2 when its path is closed in the current switch set
  assign loc_next = sw_reg[SW_M2R] & sw_reg[SW_G2S];

  // Codes are in 6 ohm steps; the kelvin code of the ground contact is
  // the return drop, subtracted and clamped at zero
  always_comb begin
    if (loc_next) begin
      mic_code = ring2_code;
      gnd_code = sleeve_kelvin_code;
    end else begin
      mic_code = sleeve_code;
      gnd_code = ring2_kelvin_input;
    end
    if (mic_code > gnd_code) begin
      eq_code = mic_code - gnd_code;
    end else begin
      eq_code = '0;
    end
  end

  // Bins by strict compare; out of order thresholds give wrong keys
  always_comb begin
    if (eq_code < th_low_reg) begin
      bin_next = KEY_1;
    end else if (eq_code < th_mid_reg) begin
      bin_next = KEY_2;
    end else if (eq_code < th_high_reg) begin
      bin_next = KEY_3;
    end else begin
      bin_next = KEY_4;
    end
  end

  // Live bin tracks the line every cycle, thresholds included
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bin_reg <= KEY_4;
      loc_reg <= 1'b0;
    end else begin
      bin_reg <= bin_next;
      loc_reg <= loc_next;
    end
  end

  // ----------------------------------------------------------------
  // Key flags
  // ----------------------------------------------------------------
  // A release belongs to the key last pressed
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_bin_reg <= KEY_1;
    end else if (key_press_valid) begin
      last_bin_reg <= bin_next;
    end
  end

  always_comb begin
    press_hot = '0;
    rel_hot   = '0;
    if (key_press_valid) begin
      press_hot[bin_next] = 1'b1;
    end
    if (key_release_valid) begin
      rel_hot[last_bin_reg] = 1'b1;
    end
  end

  // Set beats clear so no event is lost in the clear cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      press_reg   <= '0;
      release_reg <= '0;
    end else begin
      press_reg   <= (press_reg & ~press_clear) | press_hot;
      release_reg <= ((release_reg & ~release_clear) & ~press_hot) | rel_hot;
    end
  end

  // Interrupt level follows the flags one cycle later
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |{press_reg, release_reg};
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_none_state: assert property (
    !manual_en && acc_state == ASK_NONE |=> sw_reg == SWS_NONE)
    else $error("no accessory switch set wrong");

  a_detect_state: assert property (
    !manual_en && acc_state == ASK_DETECT |=> sw_reg == SWS_DETECT)
    else $error("detection switch set wrong");

  a_three_pole: assert property (
    !manual_en && acc_state == ASK_P3_FM |=> sw_reg == SWS_P3_FM)
    else $error("3-pole FM switch set wrong");

  a_ring2_mic: assert property (
    !manual_en && acc_state == ASK_RING2 |=> sw_reg == SWS_RING2 ##1 loc_reg)
    else $error("ring2 headset set or mic location wrong");

  a_std_mic: assert property (
    !manual_en && acc_state == ASK_STD |=> sw_reg == SWS_STD ##1 !loc_reg)
    else $error("standard headset set or mic location wrong");

  a_manual_wins: assert property (
    manual_en |=> sw_reg == $past(manual_sw))
    else $error("manual switch setting not applied");

  a_low_write: assert property (
    reg_wr && reg_addr == ADDR_BOUND_LOW
    |=> th_low_reg == $past(reg_wdata[TH_W-1:0]))
    else $error("low boundary write lost");

  a_top_zero: assert property (
    reg_rd |=> rdata_reg[TH_W] == 1'b0)
    else $error("threshold top bit not zero");

  a_live_bin: assert property (
    eq_code < th_low_reg |=> bin_reg == KEY_1)
    else $error("bin not from current threshold");

  a_high_bin: assert property (
    eq_code >= th_high_reg && th_high_reg > th_mid_reg
    && th_mid_reg > th_low_reg |=> bin_reg == KEY_4)
    else $error("key four bin wrong");

  a_press_flag: assert property (
    key_press_valid |=> press_reg[$past(bin_next)]
    && !release_reg[$past(bin_next)] ##1 irq_reg)
    else $error("press flag, release clear or interrupt wrong");

  a_kelvin_sub: assert property (
    !loc_next && sleeve_code <= ring2_kelvin_input |-> eq_code == '0)
    else $error("offset not cancelled");

  a_p3_plain: assert property (
    !manual_en && acc_state == ASK_P3 |=> sw_reg == SWS_P3)
    else $error("3-pole switch set wrong");

  a_ring2_fm: assert property (
    !manual_en && acc_state == ASK_RING2_FM |=> sw_reg == SWS_RING2_FM ##1 loc_reg)
    else $error("ring2 FM headset set or mic location wrong");

  a_std_fm: assert property (
    !manual_en && acc_state == ASK_STD_FM |=> sw_reg == SWS_STD_FM ##1 !loc_reg)
    else $error("standard FM headset set or mic location wrong");

  // A corrupted state code must fall back to the unpowered set
  a_bad_state: assert property (
    !manual_en && !$onehot(acc_state) |=> sw_reg == SWS_NONE)
    else $error("unknown state did not fall back");

  a_mid_write: assert property (
    reg_wr && reg_addr == ADDR_BOUND_MID
    |=> th_mid_reg == $past(reg_wdata[TH_W-1:0]))
    else $error("mid boundary write lost");

  a_high_write: assert property (
    reg_wr && reg_addr == ADDR_BOUND_HIGH
    |=> th_high_reg == $past(reg_wdata[TH_W-1:0]))
    else $error("high boundary write lost");

  // Read returns the value held before any write in the same cycle
  a_low_read: assert property (
    reg_rd && reg_addr == ADDR_BOUND_LOW
    |=> rdata_reg == {1'b0, $past(th_low_reg)})
    else $error("low boundary read wrong");

endmodule

//--- verification/ask_headset.sv
// Behavioural headset on the jack side of the switch router.
// Assumes codes of 6 ohm per LSB and that key_code plus offset stays below 128.
`timescale 1ns/10ps
module ask_headset (
  input  wire logic [6:0] key_code,
  input  wire logic       mic_ring2,
  input  wire logic [6:0] offset,
  output logic [6:0]      sleeve_code,
  output logic [6:0]      ring2_code,
  output logic [6:0]      sleeve_kelvin_code,
  output logic [6:0]      ring2_kelvin_input
);
  // ----------------------------------------------------------------
  // Contact levels
  // ----------------------------------------------------------------
  // Mic contact carries key plus ground drop; the ground side kelvin pin sees only the drop
  // The mic side kelvin reads inverted junk, so a wrong pick shows up
  always_comb begin
    sleeve_code        = mic_ring2 ? offset : key_code + offset;
    ring2_code         = mic_ring2 ? key_code + offset : offset;
    sleeve_kelvin_code = mic_ring2 ? offset : ~offset;
    ring2_kelvin_input = mic_ring2 ? ~offset : offset;
  end
endmodule

//--- verification/tb.sv
// Self-checking bench for the switch router and key classifier.
// Assumes ask_pkg is compiled first and the headset model stands on the jack.
`timescale 1ns/10ps
module tb;
  import ask_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic            clk = 1'b0;
  logic            rst_n = 1'b0;
  ask_acc_e        acc_state = ASK_NONE;
  logic            manual_en = 1'b0;
  logic [SW_W-1:0] manual_sw = '0;
  logic [7:0]      reg_addr = 8'h00;
  logic [7:0]      reg_wdata = 8'h00;
  logic            reg_wr = 1'b0;
  logic            reg_rd = 1'b0;
  logic            key_press_valid = 1'b0;
  logic            key_release_valid = 1'b0;
  logic [3:0]      press_clear = 4'h0;
  logic [3:0]      release_clear = 4'h0;
  logic [6:0]      key_code = 7'h00;
  logic            mic_ring2 = 1'b0;
  logic [6:0]      offset = 7'h05;
  logic [6:0]      s_code, r_code, s_kel, r_kel;
  logic [SW_W-1:0] switch_on;
  logic [7:0]      reg_rdata;
  logic [1:0]      key_bin;
  logic            mic_on_ring2, key_irq;
  logic [3:0]      key_press_flag, key_release_flag;
  int              failures = 0;
  int              compares = 0;
  // Switch sets per one-hot state, bit 9 sleeve depletion down to bit 0
  localparam logic [9:0] SW_EXP [8] = '{10'h300, 10'h002, 10'h3F1, 10'h061,
                                        10'h298, 10'h098, 10'h164, 10'h064};
  // Default bin edges and limits at 16, 34, 53 codes
  localparam logic [6:0] CODES [14] = '{7'h00, 7'h0B, 7'h0F, 7'h10, 7'h15, 7'h1A, 7'h21,
                                        7'h22, 7'h26, 7'h2C, 7'h34, 7'h35, 7'h3C, 7'h71};
  localparam logic [1:0] BINS [14] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h1, 2'h1,
                                       2'h2, 2'h2, 2'h2, 2'h2, 2'h3, 2'h3, 2'h3};

  ask_core ask_core_i (.clk(clk), .rst_n(rst_n), .acc_state(acc_state),
    .manual_en(manual_en), .manual_sw(manual_sw), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .sleeve_code(s_code),
    .ring2_code(r_code), .sleeve_kelvin_code(s_kel), .ring2_kelvin_input(r_kel),
    .key_press_valid(key_press_valid), .key_release_valid(key_release_valid),
    .press_clear(press_clear), .release_clear(release_clear), .switch_on(switch_on),
    .reg_rdata(reg_rdata), .key_bin(key_bin), .mic_on_ring2(mic_on_ring2),
    .key_press_flag(key_press_flag), .key_release_flag(key_release_flag),
    .key_irq(key_irq));
  ask_headset ask_headset_i (.key_code(key_code), .mic_ring2(mic_ring2), .offset(offset),
    .sleeve_code(s_code), .ring2_code(r_code), .sleeve_kelvin_code(s_kel),
    .ring2_kelvin_input(r_kel));

  // Clock at 250 MHz
  initial begin
    forever #2 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Inputs move 1 ns after the edge so no race with the design's sampling
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Idle cycle after each strobe keeps one assignment per time step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    step(1);
    reg_wr = 1'b0;
    step(1);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    step(1);
    reg_rd = 1'b0;
    chk(reg_rdata, exp);
    step(1);
  endtask
  task automatic give_verdict();
    if (failures == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_switch();
    for (int i = 0; i < 8; i++) begin
      acc_state = ask_acc_e'(8'h01 << i);
      step(1);
      chk(switch_on, SW_EXP[i]);
      step(1);
      chk(mic_on_ring2, (i == 4 || i == 5));
    end
    // A code that is not one-hot must leave the safe default
    acc_state = ask_acc_e'(8'h03);
    step(1);
    chk(switch_on, 10'h300);
  endtask
  task automatic t_manual();
    acc_state = ASK_STD;
    manual_sw = 10'h2A5;
    manual_en = 1'b1;
    step(1);
    chk(switch_on, 10'h2A5);
    manual_en = 1'b0;
    step(1);
    chk(switch_on, 10'h164);
  endtask
  task automatic t_regs();
    rd_chk(8'h0D, 8'h10);
    rd_chk(8'h0E, 8'h22);
    rd_chk(8'h0F, 8'h35);
    rd_chk(8'h0C, 8'h00);
    wr(8'h0D, 8'hFF);
    rd_chk(8'h0D, 8'h7F);
    wr(8'h0D, 8'h10);
  endtask
  // Kelvin offset of 5 must cancel on whichever contact holds the mic
  task automatic t_bins(input ask_acc_e acc, input logic ring2);
    acc_state = acc;
    mic_ring2 = ring2;
    step(2);
    for (int j = 0; j < 14; j++) begin
      key_code = CODES[j];
      step(1);
      chk(key_bin, BINS[j]);
    end
  endtask
  task automatic t_live();
    wr(8'h0D, 8'h08);
    wr(8'h0E, 8'h14);
    wr(8'h0F, 8'h28);
    key_code = 7'h08;
    step(1);
    chk(key_bin, 2'h1);
    key_code = 7'h14;
    step(1);
    chk(key_bin, 2'h2);
    key_code = 7'h27;
    step(1);
    chk(key_bin, 2'h2);
    key_code = 7'h28;
    step(1);
    chk(key_bin, 2'h3);
  endtask
  task automatic t_flags();
    key_code = 7'h19;
    step(1);
    key_press_valid = 1'b1;
    step(1);
    key_press_valid = 1'b0;
    chk(key_press_flag, 4'h4);
    step(1);
    chk(key_irq, 1'b1);
    key_release_valid = 1'b1;
    step(1);
    key_release_valid = 1'b0;
    chk(key_release_flag, 4'h4);
    key_press_valid = 1'b1;
    step(1);
    key_press_valid = 1'b0;
    chk(key_release_flag, 4'h0);
    press_clear = 4'hF;
    release_clear = 4'hF;
    step(1);
    press_clear = 4'h0;
    release_clear = 4'h0;
    chk(key_press_flag, 4'h0);
    step(1);
    chk(key_irq, 1'b0);
  endtask
  // Mid-run reset must drop a set flag and restore the low boundary
  task automatic t_reset();
    key_press_valid = 1'b1;
    step(1);
    key_press_valid = 1'b0;
    chk(key_press_flag, 4'h4);
    rst_n = 1'b0;
    step(1);
    chk(key_press_flag, 4'h0);
    chk(key_irq, 1'b0);
    chk(key_bin, 2'h3);
    chk(reg_rdata, 8'h00);
    chk(switch_on, 10'h300);
    chk(mic_on_ring2, 1'b0);
    rst_n = 1'b1;
    step(1);
    chk(switch_on, 10'h098);
    rd_chk(8'h0D, 8'h10);
  endtask
  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    #1;
    chk(switch_on, 10'h300);
    rst_n = 1'b1;
    step(1);
    t_switch();
    t_manual();
    t_regs();
    t_bins(ASK_STD, 1'b0);
    t_bins(ASK_RING2_FM, 1'b1);
    t_live();
    t_flags();
    t_reset();
    give_verdict();
  end
  initial begin
    #100000;
    failures++;
    give_verdict();
  end
endmodule
